/* verilog/gtff_pkg.sv */
// Package for the gated trigger flip-flop: constants and carrier types
package gtff_pkg;
   // Clock period in ns (25 MHz)
   localparam int GTFF_CLK_NS = 40;
   // Gate settle waits, in us as printed
   localparam int GTFF_OPEN_WAIT_US = 17;
   localparam int GTFF_CLOSE_WAIT_US = 25;
   localparam int GTFF_SHIFT_WAIT_US = 11;
   localparam int GTFF_SHIFT_WINDOW_US = 2;
   // Least waits round up, the shift window rounds down
   localparam int GTFF_OPEN_WAIT_CYC =
      (GTFF_OPEN_WAIT_US * 1000 + GTFF_CLK_NS - 1) / GTFF_CLK_NS;
   localparam int GTFF_CLOSE_WAIT_CYC =
      (GTFF_CLOSE_WAIT_US * 1000 + GTFF_CLK_NS - 1) / GTFF_CLK_NS;
   localparam int GTFF_SHIFT_WAIT_CYC =
      (GTFF_SHIFT_WAIT_US * 1000 + GTFF_CLK_NS - 1) / GTFF_CLK_NS;
   localparam int GTFF_SHIFT_WINDOW_CYC =
      (GTFF_SHIFT_WINDOW_US * 1000) / GTFF_CLK_NS;
   localparam int GTFF_CNT_W = 10;
   // Shift chain trigger ceiling and the least trigger period it gives
   localparam int GTFF_SHIFT_RATE_KHZ = 70;
   localparam int GTFF_SHIFT_PERIOD_CYC =
      (1000000 + GTFF_SHIFT_RATE_KHZ * GTFF_CLK_NS - 1) /
      (GTFF_SHIFT_RATE_KHZ * GTFF_CLK_NS);
   // Gap after a shift chain gate change: the longer of both limits
   localparam int GTFF_SHIFT_GAP_CYC =
      (GTFF_SHIFT_PERIOD_CYC > GTFF_SHIFT_WAIT_CYC) ?
      GTFF_SHIFT_PERIOD_CYC : GTFF_SHIFT_WAIT_CYC;
   // Reset state: side one off, so true output low
   localparam logic GTFF_RESET_STATE = 1'h0;

   // Inputs from the neighbouring stage (1 = positive level / gate open)
   typedef struct packed {
      logic direct_level_side_one;
      logic direct_level_side_two;
      logic steer_gate_side_one;
      logic steer_gate_side_two;
      logic trigger;
   } gtff_in_type;
endpackage : gtff_pkg

/* verilog/gtff_sync.sv */
// Two-stage synchroniser for the cell's pin inputs
`timescale 1ns/1ps
module gtff_sync
   import gtff_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Data
   input wire gtff_in_type async_i,
   output gtff_in_type sync_o
);
   gtff_in_type meta_reg;
   gtff_in_type sync_reg;

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule : gtff_sync

/* verilog/gtff_cell.sv */
// Gated trigger flip-flop cell with direct level inputs
`timescale 1ns/1ps
module gtff_cell
   import gtff_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Direct level inputs, high turns the side off
   input wire logic direct_level_side_one_i,
   input wire logic direct_level_side_two_i,
   // Steering gates, high means open
   input wire logic steer_gate_side_one_i,
   input wire logic steer_gate_side_two_i,
   // Shared trigger, acts on its rising edge
   input wire logic trigger_i,
   // Outputs
   output logic true_output_o,
   output logic complement_output_o
);
   gtff_in_type pins_async;
   gtff_in_type pins;
   logic trig_last_reg;
   logic trig_last_next;
   logic state_reg;
   logic state_next;
   logic true_reg;
   logic true_next;
   logic comp_reg;
   logic comp_next;
   logic trig_rise;
   logic side_one_switch;
   logic side_two_switch;

   assign pins_async = '{direct_level_side_one: direct_level_side_one_i,
                         direct_level_side_two: direct_level_side_two_i,
                         steer_gate_side_one: steer_gate_side_one_i,
                         steer_gate_side_two: steer_gate_side_two_i,
                         trigger: trigger_i};

   // Pins come from another stage with no shared clock
   gtff_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i(pins_async),
      .sync_o(pins)
   );

   // state_reg high means side one conducts, so true output is high
   always_comb
   begin
      trig_last_next = pins.trigger;
      trig_rise = pins.trigger && !trig_last_reg;
      side_one_switch = state_reg;
      side_two_switch = !state_reg;
      // Gate high counts as open; low holds its side
      if (trig_rise && pins.steer_gate_side_one)
      begin
         side_one_switch = 1'h0;
      end
      if (trig_rise && pins.steer_gate_side_two)
      begin
         side_two_switch = 1'h0;
      end
      // Direct levels win over any trigger in the same cycle
      // A lone direct level also holds the far side on, so a trigger
      // on the other gate cannot slip a one-cycle glitch through
      if (pins.direct_level_side_one)
      begin
         side_one_switch = 1'h0;
         side_two_switch = !pins.direct_level_side_two;
      end
      else if (pins.direct_level_side_two)
      begin
         side_one_switch = 1'h1;
         side_two_switch = 1'h0;
      end
      // A side turned off makes the other conduct; otherwise hold
      if (!side_one_switch && state_reg)
      begin
         state_next = 1'h0;
      end
      else if (!side_two_switch && !state_reg)
      begin
         state_next = 1'h1;
      end
      else
      begin
         state_next = state_reg;
      end
      // Both gates open with the neighbour misbehaving simply toggles
      true_next = state_next;
      comp_next = !state_next;
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         trig_last_reg <= 1'h0;
         state_reg <= GTFF_RESET_STATE;
         true_reg <= GTFF_RESET_STATE;
         comp_reg <= !GTFF_RESET_STATE;
      end
      else
      begin
         trig_last_reg <= trig_last_next;
         state_reg <= state_next;
         true_reg <= true_next;
         comp_reg <= comp_next;
      end
   end

   assign true_output_o = true_reg;
   assign complement_output_o = comp_reg;

   // Checks read the synchronised pins, as the state logic does
   chk_outputs_complement: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      true_output_o != complement_output_o)
      else $error("outputs not complementary");

   chk_direct_one_off: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.direct_level_side_one && !pins.direct_level_side_two
      |=> !true_output_o)
      else $error("direct level one did not turn side one off");

   chk_direct_two_off: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.direct_level_side_two && !pins.direct_level_side_one
      |=> true_output_o)
      else $error("direct level two did not turn side two off");

   chk_gate_one_trig: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && pins.steer_gate_side_one &&
      !pins.steer_gate_side_two && !pins.direct_level_side_one &&
      !pins.direct_level_side_two |=> !true_output_o)
      else $error("trigger did not turn off gated side one");

   chk_closed_gates_hold: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !pins.steer_gate_side_one && !pins.steer_gate_side_two &&
      !pins.direct_level_side_one && !pins.direct_level_side_two
      |=> $stable(true_output_o))
      else $error("closed gates changed the state");

   chk_state_holds: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !$rose(pins.trigger) && !pins.direct_level_side_one &&
      !pins.direct_level_side_two |=> $stable(true_output_o))
      else $error("state changed without cause");

   chk_gate_two_trig: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && pins.steer_gate_side_two &&
      !pins.steer_gate_side_one && !pins.direct_level_side_one &&
      !pins.direct_level_side_two |=> true_output_o)
      else $error("trigger did not turn off gated side two");

   chk_direct_one_wins: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.direct_level_side_one && !pins.direct_level_side_two &&
      $rose(pins.trigger) && pins.steer_gate_side_two |=> !true_output_o)
      else $error("trigger overrode direct level one");

   chk_direct_two_wins: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.direct_level_side_two && !pins.direct_level_side_one &&
      $rose(pins.trigger) && pins.steer_gate_side_one |=> true_output_o)
      else $error("trigger overrode direct level two");

   chk_closed_gate_one: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && !pins.steer_gate_side_one &&
      pins.steer_gate_side_two && !pins.direct_level_side_one &&
      !pins.direct_level_side_two && true_output_o |=> true_output_o)
      else $error("closed gate one let side one turn off");

   chk_closed_gate_two: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && !pins.steer_gate_side_two &&
      pins.steer_gate_side_one && !pins.direct_level_side_one &&
      !pins.direct_level_side_two && !true_output_o |=> !true_output_o)
      else $error("closed gate two let side two turn off");

   chk_release_holds: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $fell(pins.direct_level_side_two) && !pins.direct_level_side_one &&
      !$rose(pins.trigger) |=> $stable(true_output_o))
      else $error("releasing direct level two changed the state");

   chk_complement_follows: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $changed(true_output_o) |-> $changed(complement_output_o))
      else $error("complement output lagged the true output");

   // Scenarios the bench is meant to reach

   cov_trigger_side_one: cover property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && pins.steer_gate_side_one && true_output_o);
   cov_trigger_side_two: cover property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && pins.steer_gate_side_two && !true_output_o);
   cov_direct_set: cover property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.direct_level_side_two ##1 true_output_o);
   cov_direct_clear: cover property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.direct_level_side_one ##1 !true_output_o);
   cov_shift_hold: cover property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(pins.trigger) && !pins.steer_gate_side_one &&
      pins.steer_gate_side_two && true_output_o);
endmodule : gtff_cell

/* dv/gtff_neighbour.sv */
// Neighbouring stage model that drives the cell's pins
`timescale 1ns/1ps
module gtff_neighbour
   import gtff_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Pin levels towards the cell
   output gtff_in_type pins_o
);
   initial pins_o = '0;
   task automatic gates(input logic g1, input logic g2);
      logic closing;
      closing = (pins_o.steer_gate_side_one & !g1) |
         (pins_o.steer_gate_side_two & !g2);
      @(posedge clk_sys_i);
      pins_o.steer_gate_side_one <= g1;
      pins_o.steer_gate_side_two <= g2;
      // Closing settles slower than opening
      repeat (closing ? GTFF_CLOSE_WAIT_CYC : GTFF_OPEN_WAIT_CYC)
         @(posedge clk_sys_i);
   endtask : gates
   task automatic fire();
      @(posedge clk_sys_i);
      if (!(pins_o.steer_gate_side_one & pins_o.steer_gate_side_two))
         pins_o.trigger <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      pins_o.trigger <= 1'h0;
      repeat (GTFF_SHIFT_PERIOD_CYC) @(posedge clk_sys_i);
   endtask : fire
   task automatic shift(input logic g1, input logic g2);
      @(posedge clk_sys_i);
      if (!(pins_o.steer_gate_side_one & pins_o.steer_gate_side_two))
         pins_o.trigger <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      pins_o.trigger <= 1'h0;
      // Gates move well inside the window that follows the edge
      pins_o.steer_gate_side_one <= g1;
      pins_o.steer_gate_side_two <= g2;
      repeat (GTFF_SHIFT_GAP_CYC) @(posedge clk_sys_i);
   endtask : shift
   task automatic direct(input logic d1, input logic d2);
      @(posedge clk_sys_i);
      pins_o.direct_level_side_one <= d1;
      pins_o.direct_level_side_two <= d2;
      repeat (4) @(posedge clk_sys_i);
   endtask : direct
endmodule : gtff_neighbour

/* dv/gated_trigger_flip_flop_test.sv */
// Self-checking bench for the gated trigger flip-flop cell
`timescale 1ns/1ps
module gated_trigger_flip_flop_test;
   import gtff_pkg::*;
   logic clk_sys_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic true_output_o;
   logic complement_output_o;
   gtff_in_type pins;
   int fails = 0;
   int checks_done = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   gtff_neighbour nbr (.clk_sys_i(clk_sys_i), .pins_o(pins));
   gtff_cell dut (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .direct_level_side_one_i(pins.direct_level_side_one),
      .direct_level_side_two_i(pins.direct_level_side_two),
      .steer_gate_side_one_i(pins.steer_gate_side_one),
      .steer_gate_side_two_i(pins.steer_gate_side_two),
      .trigger_i(pins.trigger),
      .true_output_o(true_output_o),
      .complement_output_o(complement_output_o)
   );
   task automatic check_state(input string what, input logic exp);
      #1;
      checks_done++;
      if (true_output_o !== exp || complement_output_o !== ~exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h %0h", what, exp,
            true_output_o, complement_output_o);
      end
   endtask : check_state
   task automatic test_direct();
      nbr.direct(1'h0, 1'h1);
      check_state("direct two", 1'h1);
      nbr.direct(1'h0, 1'h0);
      check_state("hold", 1'h1);
      nbr.direct(1'h1, 1'h0);
      check_state("direct one", 1'h0);
      nbr.direct(1'h0, 1'h0);
   endtask : test_direct
   task automatic test_gated();
      nbr.direct(1'h0, 1'h1);
      nbr.direct(1'h0, 1'h0);
      nbr.gates(1'h1, 1'h0);
      nbr.fire();
      check_state("gate one", 1'h0);
      nbr.fire();
      check_state("gate one again", 1'h0);
      nbr.gates(1'h0, 1'h1);
      nbr.fire();
      check_state("gate two", 1'h1);
      nbr.gates(1'h0, 1'h0);
      nbr.fire();
      check_state("both closed", 1'h1);
   endtask : test_gated
   task automatic test_override();
      nbr.direct(1'h1, 1'h0);
      nbr.gates(1'h0, 1'h1);
      nbr.fire();
      check_state("direct wins", 1'h0);
      nbr.direct(1'h0, 1'h0);
      nbr.gates(1'h0, 1'h0);
      check_state("release", 1'h0);
      nbr.direct(1'h0, 1'h1);
      nbr.gates(1'h1, 1'h0);
      nbr.fire();
      check_state("direct two wins", 1'h1);
      nbr.direct(1'h0, 1'h0);
      nbr.gates(1'h0, 1'h0);
   endtask : test_override
   task automatic test_shift();
      nbr.gates(1'h1, 1'h0);
      nbr.shift(1'h0, 1'h1);
      check_state("shift one", 1'h0);
      nbr.shift(1'h0, 1'h1);
      check_state("shift two", 1'h1);
      nbr.shift(1'h1, 1'h0);
      check_state("shift hold", 1'h1);
      nbr.shift(1'h0, 1'h0);
      check_state("shift three", 1'h0);
   endtask : test_shift
   task automatic test_reset();
      nbr.direct(1'h0, 1'h1);
      nbr.direct(1'h0, 1'h0);
      @(posedge clk_sys_i);
      rst_b_i <= 1'h0;
      repeat (2) @(posedge clk_sys_i);
      check_state("mid reset", 1'h0);
      @(posedge clk_sys_i);
      rst_b_i <= 1'h1;
      nbr.direct(1'h0, 1'h1);
      check_state("after mid reset", 1'h1);
      nbr.direct(1'h0, 1'h0);
   endtask : test_reset
   task automatic end_sim();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'h1;
      check_state("after reset", 1'h0);
      test_direct();
      test_gated();
      test_override();
      test_shift();
      test_reset();
      end_sim();
   end
endmodule : gated_trigger_flip_flop_test
